// ===== ocfs_pkg.sv
// package for the output clock frequency select block
// assumes an apb slave with 32-bit data; registers sit at four times their index
package ocfs_pkg;

  // register indices and byte addresses
  localparam logic [11:0] IDX_ALT_DECODE = 12'h04f;
  localparam logic [11:0] IDX_THIRD_RATE = 12'h061;
  localparam logic [11:0] IDX_SIXTH_RATE = 12'h062;
  localparam logic [11:0] IDX_SYNC_EN = 12'h063;
  localparam logic [11:0] IDX_SEC_FREQ = 12'h064;
  localparam logic [11:0] IDX_MAIN_FREQ = 12'h065;
  localparam logic [11:0] ADDR_ALT_DECODE = 12'(IDX_ALT_DECODE * 4);
  localparam logic [11:0] ADDR_THIRD_RATE = 12'(IDX_THIRD_RATE * 4);
  localparam logic [11:0] ADDR_SIXTH_RATE = 12'(IDX_SIXTH_RATE * 4);
  localparam logic [11:0] ADDR_SYNC_EN = 12'(IDX_SYNC_EN * 4);
  localparam logic [11:0] ADDR_SEC_FREQ = 12'(IDX_SEC_FREQ * 4);
  localparam logic [11:0] ADDR_MAIN_FREQ = 12'(IDX_MAIN_FREQ * 4);

  // field positions
  localparam int ALT3_BIT = 2;
  localparam int ALT6_BIT = 5;
  localparam int SIXTH_LSB = 4;
  localparam int MFS_EN_BIT = 7;
  localparam int FS_EN_BIT = 6;
  localparam int SRC_MAIN_BIT = 6;
  localparam int M2S_LSB = 3;

  // reset values before the straps are taken, the strap load cycle and the highest secondary code
  localparam logic [3:0] RATE_RESET = 4'h0;
  localparam logic [2:0] SYNTH_RESET = 3'h0;
  localparam logic [1:0] STRAP_LOAD_CYCLE = 2'h2;
  localparam logic [3:0] SEC_CODE_MAX = 4'hc;

  // clock sources the outputs can follow
  typedef enum logic [3:0] {
    SRC_MAIN, SRC_MAIN2, SRC_SEC, SRC_REF_MAIN, SRC_REF_SEC, SRC_AUX1, SRC_AUX2, SRC_F2K, SRC_F8K
  } ocfs_src_t;
  localparam int NSRC = 9;

  // one output's selection: enable, source and half-period in source edges minus one
  typedef struct packed {
    logic en;
    ocfs_src_t src;
    logic [5:0] div_m1;
  } ocfs_sel_t;

  // apb request group
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ocfs_apb_req_t;

endpackage

// ===== ocfs_top.sv
// output clock frequency selection with apb registers and strap defaults
// assumes source clocks arrive from other domains and are sampled on pclk
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// one glitch-free divided output
module ocfs_channel #(
  parameter int N = 9
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // source edges and selection
  input wire logic [N-1:0] src_edge,
  input wire ocfs_pkg::ocfs_sel_t next_sel,
  // divided output
  output logic clk_out
);
  ocfs_pkg::ocfs_sel_t cur;
  logic [5:0] cnt;
  logic active_edge;
  logic switch_now;

  // edges of the adopted source; switch only while the output rests low
  assign active_edge = src_edge[int'(cur.src)];
  assign switch_now = (next_sel != cur) && !clk_out;

  // half-period counter toggles the output every div_m1+1 source edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cnt <= 6'h00;
      clk_out <= 1'b0;
    end else if (switch_now) begin
      cur <= next_sel;
      cnt <= 6'h00;
    end else if (!cur.en) begin
      clk_out <= 1'b0;
    end else if (active_edge) begin
      if (cnt == cur.div_m1) begin
        clk_out <= ~clk_out;
        cnt <= 6'h00;
      end else begin
        cnt <= cnt + 6'h01;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: apb registers, straps, decoders and four output channels
module ocfs_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // strap pins
  input wire logic [2:0] third_output_strap,
  input wire logic [2:0] sixth_output_strap,
  // source clocks, in order of ocfs_src_t
  input wire logic [ocfs_pkg::NSRC-1:0] src_clk,
  // output clocks
  output logic third_output_clock,
  output logic sixth_output_clock,
  output logic multiframe_sync_output,
  output logic frame_sync_output,
  // synthesizer rate codes to the plls
  output logic [3:0] secondary_synth_rate_code,
  output logic [2:0] main_synth_rate_code
);
  localparam int NS = ocfs_pkg::NSRC;

  // registers
  logic [3:0] third_output_rate_code;
  logic [3:0] sixth_output_rate_code;
  logic third_output_alt_decode;
  logic sixth_output_alt_decode;
  logic multiframe_sync_enable;
  logic frame_sync_enable;
  logic [3:0] sec_rate_field;
  logic secondary_source_from_main;
  logic [2:0] main_to_secondary_rate_code;
  logic [2:0] main_rate_field;
  logic [1:0] load_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for straps and source clocks, third flop for edges
  logic [5:0] strap_s1, strap_s2;
  logic [NS-1:0] src_s1, src_s2, src_s3;
  logic [NS-1:0] src_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_s1 <= 6'h00;
      strap_s2 <= 6'h00;
      src_s1 <= '0;
      src_s2 <= '0;
      src_s3 <= '0;
    end else begin
      strap_s1 <= {sixth_output_strap, third_output_strap};
      strap_s2 <= strap_s1;
      src_s1 <= src_clk;
      src_s2 <= src_s1;
      src_s3 <= src_s2;
    end
  end
  assign src_edge = src_s2 ^ src_s3; // both edges count

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire access = psel && penable;
  wire wr_now = access && pwrite && pready;
  wire hit_alt = paddr == ocfs_pkg::ADDR_ALT_DECODE;
  wire hit_third = paddr == ocfs_pkg::ADDR_THIRD_RATE;
  wire hit_sixth = paddr == ocfs_pkg::ADDR_SIXTH_RATE;
  wire hit_sync = paddr == ocfs_pkg::ADDR_SYNC_EN;
  wire hit_sec = paddr == ocfs_pkg::ADDR_SEC_FREQ;
  wire hit_main = paddr == ocfs_pkg::ADDR_MAIN_FREQ;
  wire mapped = hit_alt | hit_third | hit_sixth | hit_sync | hit_sec | hit_main;
  wire strap_load = load_cnt == ocfs_pkg::STRAP_LOAD_CYCLE;

  // read data; unused bits read zero
  wire [7:0] rd_alt = 8'({sixth_output_alt_decode, 2'b00, third_output_alt_decode, 2'b00});
  wire [7:0] rd_third = {4'h0, third_output_rate_code};
  wire [7:0] rd_sixth = {sixth_output_rate_code, 4'h0};
  wire [7:0] rd_sync = {multiframe_sync_enable, frame_sync_enable, 6'h00};
  wire [7:0] rd_sec = {4'h0, sec_rate_field};
  wire [7:0] rd_main = {1'b0, secondary_source_from_main, main_to_secondary_rate_code, main_rate_field};
  wire [7:0] rd_byte = hit_alt ? rd_alt : hit_third ? rd_third : hit_sixth ? rd_sixth :
                       hit_sync ? rd_sync : hit_sec ? rd_sec : hit_main ? rd_main : 8'h00;

  // one wait state, then answer from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access && !pready;
      prdata <= (access && !pready && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
      pslverr <= access && !pready && !mapped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes and strap load after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_cnt <= 2'h0;
      third_output_rate_code <= ocfs_pkg::RATE_RESET;
      sixth_output_rate_code <= ocfs_pkg::RATE_RESET;
      third_output_alt_decode <= 1'b0;
      sixth_output_alt_decode <= 1'b0;
      multiframe_sync_enable <= 1'b0;
      frame_sync_enable <= 1'b0;
      sec_rate_field <= ocfs_pkg::RATE_RESET;
      secondary_source_from_main <= 1'b0;
      main_to_secondary_rate_code <= ocfs_pkg::SYNTH_RESET;
      main_rate_field <= ocfs_pkg::SYNTH_RESET;
    end else begin
      if (load_cnt != 2'h3) begin
        load_cnt <= load_cnt + 2'h1;
      end
      if (strap_load) begin
        third_output_rate_code <= {1'b0, strap_s2[2:0]};
        sixth_output_rate_code <= {1'b0, strap_s2[5:3]};
        sec_rate_field <= {strap_s2[3], strap_s2[2:0]};
        main_rate_field <= strap_s2[2:0];
      end else if (wr_now) begin
        if (hit_alt) begin
          third_output_alt_decode <= pwdata[ocfs_pkg::ALT3_BIT];
          sixth_output_alt_decode <= pwdata[ocfs_pkg::ALT6_BIT];
        end
        if (hit_third) begin
          third_output_rate_code <= pwdata[3:0];
        end
        if (hit_sixth) begin
          sixth_output_rate_code <= pwdata[ocfs_pkg::SIXTH_LSB +: 4];
        end
        if (hit_sync) begin
          multiframe_sync_enable <= pwdata[ocfs_pkg::MFS_EN_BIT];
          frame_sync_enable <= pwdata[ocfs_pkg::FS_EN_BIT];
        end
        if (hit_sec) begin
          sec_rate_field <= pwdata[3:0];
        end
        if (hit_main) begin
          secondary_source_from_main <= pwdata[ocfs_pkg::SRC_MAIN_BIT];
          main_to_secondary_rate_code <= pwdata[ocfs_pkg::M2S_LSB +: 3];
          main_rate_field <= pwdata[2:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // secondary synth code: direct field or mapped main-to-secondary field
  logic [3:0] m2s_code;
  always_comb begin
    case (main_to_secondary_rate_code)
      3'h0: m2s_code = 4'h2;
      3'h1: m2s_code = 4'h9;
      3'h2: m2s_code = 4'h3;
      3'h4: m2s_code = 4'h4;
      3'h6: m2s_code = 4'h5;
      3'h7: m2s_code = 4'h8;
      default: m2s_code = 4'h0;
    endcase
  end
  wire [3:0] sec_pick = secondary_source_from_main ? m2s_code : sec_rate_field;
  wire [3:0] next_sec_code = (sec_pick > ocfs_pkg::SEC_CODE_MAX) ? 4'h0 : sec_pick;
  wire sec_ok = next_sec_code != 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_synth_rate_code <= 4'h0;
      main_synth_rate_code <= ocfs_pkg::SYNTH_RESET;
    end else begin
      secondary_synth_rate_code <= next_sec_code;
      main_synth_rate_code <= main_rate_field;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // selection helpers; n is the division ratio
  function automatic ocfs_pkg::ocfs_sel_t mk(input logic en, input ocfs_pkg::ocfs_src_t s, input int n);
    ocfs_pkg::ocfs_sel_t r;
    r.en = en;
    r.src = en ? s : ocfs_pkg::SRC_MAIN;
    r.div_m1 = en ? 6'(n - 1) : 6'h00;
    return r;
  endfunction

  // standard codes 11..15 shared by both outputs
  function automatic ocfs_pkg::ocfs_sel_t sec_std(input logic [3:0] c, input logic ok);
    case (c)
      4'hb: return mk(ok, ocfs_pkg::SRC_SEC, 64);
      4'hc: return mk(ok, ocfs_pkg::SRC_SEC, 48);
      4'hd: return mk(ok, ocfs_pkg::SRC_SEC, 16);
      4'he: return mk(ok, ocfs_pkg::SRC_SEC, 8);
      default: return mk(ok, ocfs_pkg::SRC_SEC, 4);
    endcase
  endfunction

  // third output decode
  function automatic ocfs_pkg::ocfs_sel_t dec_third(input logic alt, input logic [3:0] c, input logic ok);
    if (!alt) begin
      case (c)
        4'h1: return mk(1'b1, ocfs_pkg::SRC_F2K, 1);
        4'h2: return mk(1'b1, ocfs_pkg::SRC_F8K, 1);
        4'h3: return mk(1'b1, ocfs_pkg::SRC_AUX2, 1);
        4'h4: return mk(1'b1, ocfs_pkg::SRC_AUX1, 1);
        4'h5: return mk(1'b1, ocfs_pkg::SRC_MAIN, 48);
        4'h6: return mk(1'b1, ocfs_pkg::SRC_MAIN, 16);
        4'h7: return mk(1'b1, ocfs_pkg::SRC_MAIN, 12);
        4'h8: return mk(1'b1, ocfs_pkg::SRC_MAIN, 8);
        4'h9: return mk(1'b1, ocfs_pkg::SRC_MAIN, 6);
        4'ha: return mk(1'b1, ocfs_pkg::SRC_MAIN, 4);
        4'h0: return mk(1'b0, ocfs_pkg::SRC_MAIN, 1);
        default: return sec_std(c, ok);
      endcase
    end
    case (c)
      4'h1: return mk(1'b1, ocfs_pkg::SRC_MAIN, 64);
      4'h2: return mk(ok, ocfs_pkg::SRC_SEC, 20);
      4'h3: return mk(ok, ocfs_pkg::SRC_SEC, 12);
      4'h4: return mk(ok, ocfs_pkg::SRC_SEC, 5);
      4'h6: return mk(ok, ocfs_pkg::SRC_SEC, 2);
      4'h8: return mk(1'b1, ocfs_pkg::SRC_REF_MAIN, 1);
      default: return mk(1'b0, ocfs_pkg::SRC_MAIN, 1);
    endcase
  endfunction

  // sixth output decode
  function automatic ocfs_pkg::ocfs_sel_t dec_sixth(input logic alt, input logic [3:0] c, input logic ok);
    if (!alt) begin
      case (c)
        4'h1: return mk(1'b1, ocfs_pkg::SRC_F2K, 1);
        4'h2: return mk(1'b1, ocfs_pkg::SRC_F8K, 1);
        4'h3: return mk(1'b1, ocfs_pkg::SRC_MAIN, 2);
        4'h4: return mk(1'b1, ocfs_pkg::SRC_AUX1, 1);
        4'h5: return mk(1'b1, ocfs_pkg::SRC_MAIN, 1);
        4'h6: return mk(1'b1, ocfs_pkg::SRC_MAIN, 16);
        4'h7: return mk(1'b1, ocfs_pkg::SRC_MAIN, 12);
        4'h8: return mk(1'b1, ocfs_pkg::SRC_MAIN, 8);
        4'h9: return mk(1'b1, ocfs_pkg::SRC_MAIN, 6);
        4'ha: return mk(1'b1, ocfs_pkg::SRC_MAIN, 4);
        4'h0: return mk(1'b0, ocfs_pkg::SRC_MAIN, 1);
        default: return sec_std(c, ok);
      endcase
    end
    case (c)
      4'h1: return mk(ok, ocfs_pkg::SRC_SEC, 5);
      4'h2: return mk(ok, ocfs_pkg::SRC_SEC, 2);
      4'h3: return mk(ok, ocfs_pkg::SRC_SEC, 1);
      4'h4: return mk(1'b1, ocfs_pkg::SRC_MAIN2, 5);
      4'h5: return mk(1'b1, ocfs_pkg::SRC_MAIN2, 2);
      4'h6: return mk(1'b1, ocfs_pkg::SRC_MAIN2, 1);
      4'h7: return mk(1'b1, ocfs_pkg::SRC_REF_SEC, 1);
      4'h8: return mk(1'b1, ocfs_pkg::SRC_REF_MAIN, 1);
      default: return mk(1'b0, ocfs_pkg::SRC_MAIN, 1);
    endcase
  endfunction

  wire ocfs_pkg::ocfs_sel_t sel_third = dec_third(third_output_alt_decode, third_output_rate_code, sec_ok);
  wire ocfs_pkg::ocfs_sel_t sel_sixth = dec_sixth(sixth_output_alt_decode, sixth_output_rate_code, sec_ok);
  wire ocfs_pkg::ocfs_sel_t sel_mfs = mk(multiframe_sync_enable, ocfs_pkg::SRC_F2K, 1);
  wire ocfs_pkg::ocfs_sel_t sel_fs = mk(frame_sync_enable, ocfs_pkg::SRC_F8K, 1);

  ////////////////////////////////////////////////////////////////////////////////
  // four output channels
  ocfs_channel #(.N(NS)) u_third (.pclk(pclk), .presetn(presetn), .src_edge(src_edge),
    .next_sel(sel_third), .clk_out(third_output_clock));
  ocfs_channel #(.N(NS)) u_sixth (.pclk(pclk), .presetn(presetn), .src_edge(src_edge),
    .next_sel(sel_sixth), .clk_out(sixth_output_clock));
  ocfs_channel #(.N(NS)) u_mfs (.pclk(pclk), .presetn(presetn), .src_edge(src_edge),
    .next_sel(sel_mfs), .clk_out(multiframe_sync_output));
  ocfs_channel #(.N(NS)) u_fs (.pclk(pclk), .presetn(presetn), .src_edge(src_edge),
    .next_sel(sel_fs), .clk_out(frame_sync_output));

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire rd_done = psel && penable && pready && !pwrite;

  property p_third_upper_zero;
    rd_done && hit_third |-> prdata[31:4] == 28'h0000000;
  endproperty
  a_third_upper_zero: assert property (p_third_upper_zero) else $error("third rate upper bits not zero");

  property p_sixth_lower_zero;
    rd_done && hit_sixth |-> prdata[3:0] == 4'h0 && prdata[31:8] == 24'h000000;
  endproperty
  a_sixth_lower_zero: assert property (p_sixth_lower_zero) else $error("sixth rate lower bits not zero");

  property p_mfs_off;
    !multiframe_sync_enable && !multiframe_sync_output |=> !multiframe_sync_output;
  endproperty
  a_mfs_off: assert property (p_mfs_off) else $error("multiframe sync pulsed while off");

  property p_fs_off;
    !frame_sync_enable [*2] ##0 !frame_sync_output |=> !frame_sync_output [*2];
  endproperty
  a_fs_off: assert property (p_fs_off) else $error("frame sync pulsed while off");

  property p_strap_load;
    strap_load |=> third_output_rate_code == {1'b0, $past(strap_s2[2:0])} &&
      sixth_output_rate_code == {1'b0, $past(strap_s2[5:3])};
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("strap defaults not loaded");

  property p_sec_direct;
    !secondary_source_from_main && sec_rate_field <= ocfs_pkg::SEC_CODE_MAX
      |=> secondary_synth_rate_code == $past(sec_rate_field);
  endproperty
  a_sec_direct: assert property (p_sec_direct) else $error("secondary code not from direct field");

  property p_sec_unused;
    secondary_source_from_main && main_to_secondary_rate_code inside {3'h3, 3'h5}
      |=> secondary_synth_rate_code == 4'h0;
  endproperty
  a_sec_unused: assert property (p_sec_unused) else $error("unused secondary code not disabled");

  property p_third_undefined;
    third_output_alt_decode && third_output_rate_code == 4'h7 && !third_output_clock [*2]
      |=> !third_output_clock;
  endproperty
  a_third_undefined: assert property (p_third_undefined) else $error("undefined code drove output");

  // a secondary-pll selection stays low while that synthesizer is disabled
  property p_third_sec_off;
    !third_output_alt_decode && third_output_rate_code > 4'ha && !sec_ok && !third_output_clock [*2]
      |=> !third_output_clock;
  endproperty
  a_third_sec_off: assert property (p_third_sec_off) else $error("output ran from disabled secondary pll");

  property p_sixth_off;
    sixth_output_rate_code == 4'h0 && !sixth_output_clock |=> !sixth_output_clock;
  endproperty
  a_sixth_off: assert property (p_sixth_off) else $error("disabled sixth output toggled");

  c_third_alt_clock: cover property (third_output_alt_decode && $rose(third_output_clock));
  c_sixth_sec: cover property (sixth_output_rate_code == 4'hb && $rose(sixth_output_clock));
  c_mfs_on: cover property ($rose(multiframe_sync_output));
  c_sec_from_main: cover property (secondary_source_from_main && sec_ok);
endmodule

// ===== ocfs_top_tb.sv
// testbench for the output clock frequency select block
// assumes free-running source clocks driven here, apb answered by ocfs_top
`timescale 1ns/1ps

module ocfs_top_tb;
  // clock, reset, bus and pins
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  ocfs_pkg::ocfs_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] t3_strap = 3'h0;
  logic [2:0] s6_strap = 3'h0;
  logic [ocfs_pkg::NSRC-1:0] src_clk = '0;
  logic o3, o6, omf, ofs;
  logic [3:0] sec_code;
  logic [2:0] main_code;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  int cnt [ocfs_pkg::NSRC] = '{default: 0};
  logic [31:0] rd;
  logic err;
  // divisor*16 + source, zero means low; third std, third alt, sixth std, sixth alt
  localparam int DEC [64] = '{0, 23, 24, 22, 21, 768, 256, 192, 128, 96, 64, 1026, 770, 258, 130, 66,
    0, 1024, 322, 194, 82, 0, 34, 0, 19, 0, 0, 0, 0, 0, 0, 0,
    0, 23, 24, 32, 21, 16, 256, 192, 128, 96, 64, 1026, 770, 258, 130, 66,
    0, 82, 34, 18, 81, 33, 17, 20, 19, 0, 0, 0, 0, 0, 0, 0};
  localparam int M2S [8] = '{2, 9, 3, 0, 4, 0, 5, 8};
  localparam logic [11:0] ADR [6] = '{ocfs_pkg::ADDR_ALT_DECODE, ocfs_pkg::ADDR_THIRD_RATE,
    ocfs_pkg::ADDR_SIXTH_RATE, ocfs_pkg::ADDR_SYNC_EN, ocfs_pkg::ADDR_SEC_FREQ, ocfs_pkg::ADDR_MAIN_FREQ};
  localparam logic [31:0] MSK [6] = '{32'h24, 32'h0f, 32'hf0, 32'hc0, 32'h0f, 32'h7f};

  ocfs_top i_ocfs_top (.pclk(pclk), .presetn(presetn), .psel(req.psel), .penable(req.penable),
    .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .third_output_strap(t3_strap), .sixth_output_strap(s6_strap), .src_clk(src_clk),
    .third_output_clock(o3), .sixth_output_clock(o6), .multiframe_sync_output(omf),
    .frame_sync_output(ofs), .secondary_synth_rate_code(sec_code), .main_synth_rate_code(main_code));

  ////////////////////////////////////////////////////////////////////////////////
  // clock; source k toggles every k+2 cycles
  initial begin
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    for (int k = 0; k < ocfs_pkg::NSRC; k++) begin
      if (cnt[k] >= k + 1) begin
        cnt[k] <= 0;
        src_clk[k] <= ~src_clk[k];
      end else begin
        cnt[k] <= cnt[k] + 1;
      end
    end
  end
  // hang guard; the full sequence needs roughly 30000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // no timeout here; if pready never comes, only the hang guard ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask
  function automatic logic outv(input int w);
    case (w)
      0: return o3;
      1: return o6;
      2: return omf;
      default: return ofs;
    endcase
  endfunction
  task automatic wait_lv(input int w, input logic v);
    int n;
    n = 0;
    while (outv(w) !== v && n < 3000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  // high time of the second full pulse, or no high at all
  task automatic chk_out(input int w, input int e);
    int n;
    n = 0;
    if (e == 0) begin
      repeat (600) @(posedge pclk);
      repeat (300) begin
        @(posedge pclk);
        if (outv(w) !== 1'b0) n++;
      end
    end else begin
      wait_lv(w, 1'b0);
      wait_lv(w, 1'b1);
      wait_lv(w, 1'b0);
      wait_lv(w, 1'b1);
      do begin
        @(posedge pclk);
        n++;
      end while (outv(w) === 1'b1 && n < 3000);
    end
    chk(32'(n), 32'((e / 16) * ((e % 16) + 2)));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int s;
    int f;
    logic [31:0] d;
    void'($urandom(32'h9dea));
    t3_strap <= 3'($urandom);
    s6_strap <= 3'($urandom);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    s = {s6_strap[0], t3_strap};
    rchk(ocfs_pkg::ADDR_THIRD_RATE, {29'h0, t3_strap});
    rchk(ocfs_pkg::ADDR_SIXTH_RATE, {25'h0, s6_strap, 4'h0});
    rchk(ocfs_pkg::ADDR_SEC_FREQ, 32'(s));
    chk({28'h0, sec_code}, 32'(s > 12 ? 0 : s));
    chk({29'h0, main_code}, {29'h0, t3_strap});
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      wr(ADR[i], d);
      rchk(ADR[i], d & MSK[i]);
    end
    apb(1'b1, 12'h000, 32'hff, rd, err);
    chk({31'h0, err}, 32'h1);
    rchk(12'h000, 32'h0);
    wr(ocfs_pkg::ADDR_MAIN_FREQ, 32'h0);
    for (int c = 0; c < 16; c++) begin
      wr(ocfs_pkg::ADDR_SEC_FREQ, 32'(c));
      rchk(ocfs_pkg::ADDR_SEC_FREQ, 32'(c));
      chk({28'h0, sec_code}, 32'(c > 12 ? 0 : c));
    end
    for (int m = 0; m < 8; m++) begin
      f = $urandom % 8;
      wr(ocfs_pkg::ADDR_MAIN_FREQ, 32'(64 + m * 8 + f));
      // the codes are registered one edge after the write lands
      repeat (2) @(posedge pclk);
      chk({28'h0, sec_code}, 32'(M2S[m]));
      chk({29'h0, main_code}, 32'(f));
    end
    wr(ocfs_pkg::ADDR_MAIN_FREQ, 32'h0);
    wr(ocfs_pkg::ADDR_SEC_FREQ, 32'h1);
    wr(ocfs_pkg::ADDR_SYNC_EN, 32'h0);
    for (int w = 0; w < 2; w++) begin
      for (int a = 0; a < 2; a++) begin
        for (int c = 0; c < 16; c++) begin
          wr(ocfs_pkg::ADDR_ALT_DECODE, 32'(a) << (w == 1 ? ocfs_pkg::ALT6_BIT : ocfs_pkg::ALT3_BIT));
          wr(w == 1 ? ocfs_pkg::ADDR_SIXTH_RATE : ocfs_pkg::ADDR_THIRD_RATE, 32'(w == 1 ? c * 16 : c));
          chk_out(w, DEC[w * 32 + a * 16 + c]);
        end
      end
    end
    wr(ocfs_pkg::ADDR_ALT_DECODE, 32'h0);
    wr(ocfs_pkg::ADDR_THIRD_RATE, 32'hf);
    wr(ocfs_pkg::ADDR_SEC_FREQ, 32'h0);
    chk_out(0, 0);
    wr(ocfs_pkg::ADDR_SYNC_EN, 32'hc0);
    chk_out(2, 23);
    chk_out(3, 24);
    wr(ocfs_pkg::ADDR_SYNC_EN, 32'h80);
    chk_out(3, 0);
    chk_out(2, 23);
    wr(ocfs_pkg::ADDR_SYNC_EN, 32'h0);
    chk_out(2, 0);
    end_of_test();
  end
endmodule
